//--- logic/audio_smi_pkg.sv
// Purpose: Shared constants for the audio SMI status and I/O fast path block
// Assumes: Register offsets are byte offsets within the audio function space
// Notes: Only bits used by this block are named
package audio_smi_pkg;
  localparam logic [7:0] OFS_CODEC_GPIO = 8'h00;
  localparam logic [7:0] OFS_CODEC_STATUS = 8'h08;
  localparam logic [7:0] OFS_STAT_CLEAR = 8'h10;
  localparam logic [7:0] OFS_STAT_MIRROR = 8'h12;
  localparam logic [7:0] OFS_TRAP_STATUS = 8'h14;
  localparam logic [7:0] OFS_TRAP_ENABLE = 8'h18;
  localparam logic [7:0] OFS_MASTER0 = 8'h20;
  localparam logic [7:0] MASTER_STRIDE = 8'h08;
  localparam int NUM_MASTERS = 6;
  localparam int BIT_GPIO_SMI_EN = 30;
  localparam int BIT_SERIAL_SMI_EN = 23;
  localparam int EN_RANGE_LO = 0;
  localparam int EN_SB_TRAP = 2;
  localparam int EN_FM_TRAP = 3;
  localparam int EN_FAST_READ = 4;
  localparam int EN_FAST_READ_LO = 9;
  localparam int EN_FAST_WRITE = 11;
  localparam int TS_XADDR_LO = 0;
  localparam int TS_SBFM_SLOW = 10;
  localparam int TS_SBFM_FAST = 13;
  localparam int TS_WRITE = 14;
  localparam int TS_INDEX_BIT = 15;
  localparam int TS_ODD_LO = 16;
  localparam int TS_EVEN_LO = 24;
  localparam int ST_TRAP = 0;
  localparam int ST_CODEC = 1;
  localparam int ST_MASTER_LO = 2;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [31:0] TRAP_STATUS_RESET = 32'h0000_0000;
  localparam logic [15:0] TRAP_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] TRAP_ENABLE_MASK = 16'h0FFF;
  localparam logic [9:0] FM_BASE = 10'h388;
  localparam logic [9:0] SB_BASE_00 = 10'h220;
  localparam logic [9:0] SB_BASE_01 = 10'h240;
  localparam logic [9:0] SB_BASE_10 = 10'h260;
endpackage

//--- logic/audio_smi_status.sv
// Purpose: Audio SMI second-level status, I/O trap and fast path handling
// Assumes: Host I/O and register strobes are one-cycle pulses on clk_sys
// Notes: Fast read data is the stored two-bit fast read field over the low six bits of the last even byte
`timescale 1ns/1ns

module audio_smi_status
  import audio_smi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register access
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // Host I/O cycles
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [9:0] ioAddr,
  input wire logic [7:0] ioWdata,
  output logic ioClaim,
  output logic [7:0] ioRdata,
  // Audio bus master state
  input wire logic [5:0] masterEnable,
  input wire logic [5:0] masterEndOfPage,
  // Codec interrupt sources
  input wire logic codecSerialIrq,
  input wire logic codecGpioIrq,
  // SMI request to the power-management function
  output logic audioSmi
);
  typedef enum logic [1:0] {
    IDX_IDLE = 2'b01,
    IDX_HELD = 2'b10
  } index_state_t;

  index_state_t idxState;
  index_state_t next_idxState;
  logic [15:0] trapEnable;
  logic [7:0] evenByte;
  logic [7:0] oddByte;
  logic indexBit;
  logic accessWrite;
  logic [9:0] trapAddr;
  logic fastSmiFlag;
  logic slowSmiFlag;
  logic trapSmi;
  logic codecSmi;
  logic [5:0] masterSmi;
  logic serialSmiEn;
  logic gpioSmiEn;
  logic [7:0] fastReadData;

  wire logic hitSb;
  wire logic hitFm;
  wire logic fastReadHit;
  wire logic fastWriteHit;
  wire logic fastWriteOn;
  wire logic fastReadOn;
  wire logic trapHit;
  wire logic readAbsorb;
  wire logic firstWrite;
  wire logic trapEvent;
  wire logic fastTrap;
  wire logic [5:0] masterEvent;
  wire logic codecEvent;
  wire logic [31:0] trapStatus;
  wire logic [7:0] smiStatus;
  wire logic evenLoad;
  wire logic oddLoad;
  wire logic indexLoad;
  wire logic trapStatusRead;
  wire logic fastSet;
  wire logic slowSet;
  wire logic selStatClear;
  wire logic selStatMirror;
  wire logic [31:0] trapEnableView;
  wire logic [31:0] codecGpioView;
  wire logic [31:0] codecStatView;
  wire logic clearRead;
  wire logic [15:0] statusView;
  wire logic selTrapEn;
  wire logic selTrapSt;
  wire logic selCodecGpio;
  wire logic selCodecStat;
  wire logic [31:0] next_regRdata;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a[7:1] == ofs[7:1]);
  endfunction

  io_trap_decode u_decode (
    .ioAddr(ioAddr),
    .rangeSel(trapEnable[EN_RANGE_LO +: 2]),
    .sbEnable(trapEnable[EN_SB_TRAP]),
    .fmEnable(trapEnable[EN_FM_TRAP]),
    .hitSb(hitSb),
    .hitFm(hitFm),
    .fastReadHit(fastReadHit),
    .fastWriteHit(fastWriteHit)
  );

  assign fastWriteOn = trapEnable[EN_FAST_WRITE];
  assign fastReadOn = trapEnable[EN_FAST_READ];
  assign trapHit = hitSb || hitFm;

  // Reads in the fast read window are answered locally
  assign readAbsorb = ioRead && fastReadOn && fastReadHit;

  // Even address of a covered pair is the index access
  assign firstWrite = ioWrite && fastWriteOn && fastWriteHit && !ioAddr[0];
  assign fastTrap = ioWrite && fastWriteOn && fastWriteHit && ioAddr[0];

  // Any trapped access except an absorbed read or a first write raises SMI
  assign trapEvent = (ioWrite || ioRead) && trapHit && !readAbsorb && !firstWrite;

  genvar m;
  generate
    for (m = 0; m < NUM_MASTERS; m++)
    begin : g_master
      assign masterEvent[m] = masterEnable[m] && masterEndOfPage[m];
    end
  endgenerate

  assign codecEvent = (codecSerialIrq && serialSmiEn) || (codecGpioIrq && gpioSmiEn);
  assign smiStatus = {masterSmi, codecSmi, trapSmi};

  assign selTrapEn = reg_hit(regAddr, OFS_TRAP_ENABLE);
  assign selTrapSt = (regAddr[7:2] == OFS_TRAP_STATUS[7:2]);
  assign selCodecGpio = (regAddr[7:2] == OFS_CODEC_GPIO[7:2]);
  assign selCodecStat = (regAddr[7:2] == OFS_CODEC_STATUS[7:2]);
  assign selStatClear = reg_hit(regAddr, OFS_STAT_CLEAR);
  assign selStatMirror = reg_hit(regAddr, OFS_STAT_MIRROR);
  assign trapEnableView = {16'h0000, trapEnable};
  assign codecGpioView = {1'b0, gpioSmiEn, 30'h0000_0000};
  assign codecStatView = {8'h00, serialSmiEn, 23'h00_0000};
  assign clearRead = regRead && selStatClear;
  assign statusView = {8'h00, smiStatus};

  assign next_regRdata =
    selStatClear ? {16'h0000, statusView} :
    selStatMirror ? {16'h0000, statusView} :
    selTrapSt ? trapStatus :
    selTrapEn ? trapEnableView :
    selCodecGpio ? codecGpioView :
    selCodecStat ? codecStatView : 32'h0000_0000;

  assign audioSmi = |smiStatus;
  assign ioClaim = readAbsorb || firstWrite;

  always_comb
  begin
    next_idxState = idxState;
    unique case (idxState)
      IDX_IDLE:
      begin
        if (firstWrite)
          next_idxState = IDX_HELD;
      end
      IDX_HELD:
      begin
        if (fastTrap || !fastWriteOn)
          next_idxState = IDX_IDLE;
        else if (firstWrite)
          next_idxState = IDX_HELD;
      end
      default:
        next_idxState = IDX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      idxState <= IDX_IDLE;
    else
      idxState <= next_idxState;
  end

  // Configuration registers; status views ignore writes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      trapEnable <= TRAP_ENABLE_RESET;
    else if (regWrite && selTrapEn)
      trapEnable <= regWdata[15:0] & TRAP_ENABLE_MASK;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      serialSmiEn <= 1'b0;
    else if (regWrite && selCodecStat)
      serialSmiEn <= regWdata[BIT_SERIAL_SMI_EN];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      gpioSmiEn <= 1'b0;
    else if (regWrite && selCodecGpio)
      gpioSmiEn <= regWdata[BIT_GPIO_SMI_EN];
  end

  // Second-level status: new events win over a clearing read
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      trapSmi <= STATUS_RESET[ST_TRAP];
    else if (clearRead)
      trapSmi <= trapEvent;
    else
      trapSmi <= trapSmi | trapEvent;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      codecSmi <= STATUS_RESET[ST_CODEC];
    else if (clearRead)
      codecSmi <= codecEvent;
    else
      codecSmi <= codecSmi | codecEvent;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      masterSmi <= STATUS_RESET[ST_MASTER_LO +: NUM_MASTERS];
    else if (clearRead)
      masterSmi <= masterEvent;
    else
      masterSmi <= masterSmi | masterEvent;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      regRdata <= 32'h0000_0000;
    else if (regRead)
      regRdata <= next_regRdata;
  end

  // Third-level status capture
  assign trapStatusRead = regRead && selTrapSt;
  assign evenLoad = firstWrite;
  assign oddLoad = ioWrite && trapHit && !firstWrite;
  assign indexLoad = firstWrite || fastTrap;
  assign fastSet = trapEvent && fastWriteOn;
  assign slowSet = trapEvent && !fastWriteOn;
  assign trapStatus = {evenByte, oddByte, indexBit, accessWrite, fastSmiFlag, 2'b00,
    slowSmiFlag, trapAddr};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      evenByte <= TRAP_STATUS_RESET[TS_EVEN_LO +: 8];
    else if (evenLoad)
      evenByte <= ioWdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      oddByte <= TRAP_STATUS_RESET[TS_ODD_LO +: 8];
    else if (oddLoad)
      oddByte <= ioWdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      indexBit <= TRAP_STATUS_RESET[TS_INDEX_BIT];
    else if (indexLoad)
      indexBit <= ioAddr[1];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      trapAddr <= TRAP_STATUS_RESET[TS_XADDR_LO +: 10];
      accessWrite <= TRAP_STATUS_RESET[TS_WRITE];
    end
    else if (trapEvent)
    begin
      trapAddr <= ioAddr;
      accessWrite <= ioWrite;
    end
  end

  // Read-to-clear flags; a trap in the clearing cycle still sets them
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      fastSmiFlag <= TRAP_STATUS_RESET[TS_SBFM_FAST];
    else if (fastSet)
      fastSmiFlag <= 1'b1;
    else if (trapStatusRead)
      fastSmiFlag <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      slowSmiFlag <= TRAP_STATUS_RESET[TS_SBFM_SLOW];
    else if (slowSet)
      slowSmiFlag <= 1'b1;
    else if (trapStatusRead)
      slowSmiFlag <= 1'b0;
  end

  // Fast read reply comes from the programmed field and the low six bits of the last index byte
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      fastReadData <= 8'h00;
    else if (readAbsorb)
      fastReadData <= {trapEnable[EN_FAST_READ_LO +: 2], trapStatus[TS_EVEN_LO +: 6]};
  end

  assign ioRdata = fastReadData;
endmodule

//--- logic/io_trap_decode.sv
// Purpose: Combinational decode of one host I/O address against trap windows
// Assumes: Ten-bit I/O address, range select from the trap enable register
// Notes: Range select 11 selects no sound card window
`timescale 1ns/1ns
module io_trap_decode
  import audio_smi_pkg::*;
(
  // Address and configuration
  input wire logic [9:0] ioAddr,
  input wire logic [1:0] rangeSel,
  input wire logic sbEnable,
  input wire logic fmEnable,
  // Decode results
  output logic hitSb,
  output logic hitFm,
  output logic fastReadHit,
  output logic fastWriteHit
);
  wire logic [9:0] sbBase;
  wire logic sbValid;
  wire logic [3:0] sbOff;
  wire logic [1:0] fmOff;
  wire logic inSb;
  wire logic inFm;

  assign sbBase = (rangeSel == 2'b00) ? SB_BASE_00 :
                  (rangeSel == 2'b01) ? SB_BASE_01 : SB_BASE_10;
  assign sbValid = (rangeSel != 2'b11);
  assign inSb = sbValid && (ioAddr[9:4] == sbBase[9:4]);
  assign inFm = (ioAddr[9:2] == FM_BASE[9:2]);
  assign sbOff = ioAddr[3:0];
  assign fmOff = ioAddr[1:0];
  assign hitSb = inSb && sbEnable;
  assign hitFm = inFm && fmEnable;
  assign fastReadHit = hitFm ||
    (hitSb && ((sbOff[3:2] == 2'b00) || (sbOff == 4'h8) || (sbOff == 4'h9)));
  assign fastWriteHit = (hitFm && (fmOff != 2'b01)) ||
    (hitSb && ((sbOff == 4'h0) || (sbOff == 4'h2) || (sbOff == 4'h8)));
endmodule

//--- verification/audio_smi_checker.sv
// Purpose: Port checks for the audio SMI block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
module audio_smi_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register and I/O side
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regRdata,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [9:0] ioAddr,
  input wire logic ioClaim,
  // Event sources and request
  input wire logic [5:0] masterEnable,
  input wire logic [5:0] masterEndOfPage,
  input wire logic codecSerialIrq,
  input wire logic codecGpioIrq,
  input wire logic audioSmi
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire logic quiet = !(|(masterEnable & masterEndOfPage)) && !codecSerialIrq && !codecGpioIrq;
  a_master_raises: assert property (
    |(masterEnable & masterEndOfPage) |-> ##[1:2] audioSmi) else $error("no smi");
  a_smi_holds_set: assert property (
    audioSmi && !(regRead && regAddr == 8'h10) |=> audioSmi) else $error("smi dropped");
  a_clear_drops: assert property (
    regRead && regAddr == 8'h10 && quiet && !ioRead && !ioWrite && !$past(ioRead)
    && !$past(ioWrite) |=> !audioSmi) else $error("smi not cleared");
  a_mirror_shows: assert property (
    regRead && regAddr == 8'h12 && audioSmi |=> regRdata[7:0] != 8'h00) else $error("mirror");
  a_reserved_zero: assert property (
    regRead && (regAddr == 8'h10 || regAddr == 8'h12) |=> regRdata[15:8] == 8'h00)
    else $error("reserved bits set");
  a_claim_needs_io: assert property (
    ioClaim |-> ioRead || ioWrite) else $error("claim without cycle");
  a_claim_write_addr: assert property (
    ioClaim && ioWrite |-> !ioAddr[0] && !ioAddr[2]) else $error("bad write claim");
  a_absorbed_no_smi: assert property (
    ioClaim && !audioSmi && quiet && !$past(ioWrite) && !$past(ioRead) |=> !audioSmi)
    else $error("smi on absorbed cycle");
  a_idle_after_reset: assert property (
    $rose(rst_n) |-> !audioSmi) else $error("smi after reset");
endmodule
bind audio_smi_status audio_smi_checker chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata), .ioWrite(ioWrite),
  .ioRead(ioRead), .ioAddr(ioAddr), .ioClaim(ioClaim), .masterEnable(masterEnable),
  .masterEndOfPage(masterEndOfPage), .codecSerialIrq(codecSerialIrq),
  .codecGpioIrq(codecGpioIrq), .audioSmi(audioSmi));

//--- verification/audio_smi_status_tb_top.sv
// Purpose: Self-checking bench for the audio SMI block
// Assumes: Host model issues every register and I/O cycle
// Notes: Event inputs change at the falling edge
`timescale 1ns/1ns
module audio_smi_status_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] masterEnable = 6'h00;
  logic [5:0] masterEndOfPage = 6'h00;
  logic codecSerialIrq = 1'b0;
  logic codecGpioIrq = 1'b0;
  logic regWrite, regRead, ioWrite, ioRead, ioClaim, audioSmi;
  logic [7:0] regAddr, ioWdata, ioRdata, ioLast;
  logic [31:0] regWdata, regRdata;
  logic [9:0] ioAddr;
  int mismatches = 0;
  int cmp_count = 0;
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  audio_smi_status uut (.clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata),
    .ioClaim(ioClaim), .ioRdata(ioRdata), .masterEnable(masterEnable),
    .masterEndOfPage(masterEndOfPage), .codecSerialIrq(codecSerialIrq),
    .codecGpioIrq(codecGpioIrq), .audioSmi(audioSmi));
  host_io_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioClaim(ioClaim),
    .ioRdata(ioRdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.reg_cyc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.reg_cyc(1'b1, a, d, q);
  endtask
  task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d, input logic ec);
    logic c;
    host.io_cyc(w, a, d, c, ioLast);
    chk({31'h0, c}, {31'h0, ec});
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset();
    rd(8'h10, 32'h0);
    wr(8'h10, 32'hFFFF);
    wr(8'h12, 32'hFFFF);
    rd(8'h12, 32'h0);
  endtask
  task automatic t_masters();
    for (int n = 0; n < 6; n++)
    begin
      masterEnable = ~(6'h01 << n);
      masterEndOfPage = 6'h01 << n;
      rd(8'h12, 32'h0);
      masterEnable = 6'h01 << n;
      @(negedge clk_sys);
      masterEndOfPage = 6'h00;
      rd(8'h12, 32'h4 << n);
      rd(8'h10, 32'h4 << n);
      rd(8'h12, 32'h0);
    end
  endtask
  task automatic t_codec();
    codecSerialIrq = 1'b1;
    codecGpioIrq = 1'b1;
    rd(8'h12, 32'h0);
    wr(8'h08, 32'h0080_0000);
    rd(8'h12, 32'h2);
    chk({31'h0, audioSmi}, 32'h1);
    codecSerialIrq = 1'b0;
    wr(8'h08, 32'h0);
    rd(8'h10, 32'h2);
    wr(8'h00, 32'hC000_0000);
    rd(8'h12, 32'h2);
    codecGpioIrq = 1'b0;
    wr(8'h00, 32'h0);
    rd(8'h10, 32'h2);
    chk({31'h0, audioSmi}, 32'h0);
  endtask
  task automatic t_fast_write();
    wr(8'h18, 32'h080C);
    rd(8'h18, 32'h080C);
    io(1'b1, 10'h38A, 8'h5A, 1'b1);
    rd(8'h12, 32'h0);
    io(1'b1, 10'h38B, 8'h3C, 1'b0);
    rd(8'h12, 32'h1);
    rd(8'h14, 32'h5A3C_E38B);
    rd(8'h14, 32'h5A3C_C38B);
    for (int s = 0; s < 3; s++)
    begin
      wr(8'h18, 32'h080C | s);
      io(1'b1, 10'h220 + 10'(s * 32), 8'h11, 1'b1);
      io(1'b1, 10'h228 + 10'(s * 32), 8'h22, 1'b1);
      io(1'b1, 10'h221 + 10'(s * 32), 8'h33, 1'b0);
      io(1'b1, 10'h220 + 10'(((s + 1) % 3) * 32), 8'h44, 1'b0);
    end
    rd(8'h10, 32'h1);
  endtask
  task automatic t_fast_read();
    wr(8'h18, 32'h0E1C);
    io(1'b1, 10'h388, 8'h15, 1'b1);
    io(1'b0, 10'h389, 8'h00, 1'b1);
    chk({24'h0, ioLast}, 32'hD5);
    io(1'b0, 10'h229, 8'h00, 1'b1);
    io(1'b0, 10'h22A, 8'h00, 1'b0);
    wr(8'h18, 32'h0010);
    io(1'b0, 10'h388, 8'h00, 1'b0);
  endtask
  task automatic t_midreset();
    rd(8'h12, 32'h1);
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(8'h12, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h18, 32'h0008);
    io(1'b0, 10'h389, 8'h00, 1'b0);
    rd(8'h14, 32'h0000_0789);
    rd(8'h10, 32'h1);
  endtask
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_masters();
    t_codec();
    t_fast_write();
    t_fast_read();
    t_midreset();
    wrap_up();
  end
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule

//--- verification/host_io_model.sv
// Purpose: Host model issuing register and I/O cycles
// Assumes: One request per call, launched at the falling edge
// Notes: Idle address and data lines show the inverse of the last value
`timescale 1ns/1ns
module host_io_model (
  // Clock
  input wire logic clk_sys,
  // Register access
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  output logic [7:0] regAddr = 8'h00,
  output logic [31:0] regWdata = 32'h0000_0000,
  input wire logic [31:0] regRdata,
  // Host I/O cycles
  output logic ioWrite = 1'b0,
  output logic ioRead = 1'b0,
  output logic [9:0] ioAddr = 10'h000,
  output logic [7:0] ioWdata = 8'h00,
  input wire logic ioClaim,
  input wire logic [7:0] ioRdata
);
  task automatic reg_cyc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(negedge clk_sys);
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWdata = d;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
    q = regRdata;
  endtask
  task automatic io_cyc(input logic w, input logic [9:0] a, input logic [7:0] d,
    output logic c, output logic [7:0] q);
    @(negedge clk_sys);
    ioWrite = w;
    ioRead = !w;
    ioAddr = a;
    ioWdata = d;
    #1 c = ioClaim;
    @(negedge clk_sys);
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = ~a;
    ioWdata = ~d;
    q = ioRdata;
  endtask
endmodule
